//--- dv/omd_cpu_model.sv
// cpu core model issuing one-cycle accesses to the decoder
`timescale 1ns/100ps
module omd_cpu_model (
    input wire logic clk, // system clock
    output logic acc_valid, // access strobe
    output logic acc_write, // write flag
    output logic [15:0] acc_addr, // address
    output logic [7:0] acc_wdata // write data
);
    initial begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_addr = 16'h5a5a;
        acc_wdata = 8'h00;
    end
    // drive on the falling edge, hold across the taking edge
    task automatic issue(input logic [15:0] a, input logic w,
                         input logic [7:0] d);
        @(negedge clk);
        acc_valid = 1'b1;
        acc_write = w;
        acc_addr = a;
        acc_wdata = d;
        @(negedge clk);
        acc_valid = 1'b0;
        acc_write = 1'b0;
        // released lines must not look like the last access
        acc_addr = ~a;
        acc_wdata = ~d;
    endtask
endmodule

//--- dv/omd_decoder_assertions.sv
// assertions on the memory map decoder ports
`timescale 1ns/100ps
module omd_decoder_assertions (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic acc_valid, // access strobe
    input wire logic acc_write, // write flag
    input wire logic [15:0] acc_addr, // address
    input wire logic sel_valid_q, // result valid
    input wire logic [2:0] sel_target_q, // target code
    input wire logic [15:0] sel_offset_q, // offset
    input wire logic sel_write_q, // write flag out
    input wire logic [1:0] mode_q, // latched mode
    input wire logic [7:0] ram_reg_map_q, // map readback
    input wire logic [7:0] ee_map_q, // eeprom map readback
    input wire logic rom_present_bit_q, // rom presence
    input wire logic rom_placement_bit_q // rom placement
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // readback lags a map write, so skip two cycles after one
    sequence s_reg_hit;
        acc_valid && acc_addr[15:12] == ram_reg_map_q[3:0]
            && acc_addr[11:7] == 5'h00
            && !$past(acc_write) && !$past(acc_write, 2);
    endsequence
    sequence s_reg_answer;
        sel_target_q == omd_pkg::TGT_REG
            && sel_offset_q == {9'h000, $past(acc_addr[6:0])};
    endsequence
    a_reg_decode: assert property (s_reg_hit |=> s_reg_answer)
        else $error("register block not selected");
    a_valid_echo: assert property (acc_valid |=>
        sel_valid_q && sel_write_q == $past(acc_write))
        else $error("access not answered");
    a_idle_quiet: assert property (!acc_valid |=> !sel_valid_q)
        else $error("answer without access");
    a_reset_map: assert property ($fell(rst) |->
        ram_reg_map_q == 8'h00 && ee_map_q == 8'h00 && !sel_valid_q)
        else $error("map not cleared by reset");
    a_boot_hidden: assert property (mode_q != 2'h0 && acc_valid
        |=> sel_target_q != omd_pkg::TGT_BOOT)
        else $error("boot rom seen in normal mode");
    a_test_norom: assert property (!$past(rst) && !$past(rst, 2)
        && mode_q == 2'h2 |-> !rom_present_bit_q)
        else $error("rom present in test mode");
    a_single_high: assert property (!$past(rst) && !$past(rst, 2)
        && mode_q == 2'h1 |-> rom_placement_bit_q)
        else $error("rom placement low in single chip");
    a_rom_gate: assert property (acc_valid && !rom_present_bit_q
        |=> sel_target_q != omd_pkg::TGT_ROM)
        else $error("rom decoded while absent");
    a_single_none: assert property (!$past(rst) && mode_q == 2'h1
        && acc_valid |=> sel_target_q != omd_pkg::TGT_EXT)
        else $error("external target in single chip");
endmodule
bind omd_decoder omd_decoder_assertions chk (.*);

//--- dv/omd_decoder_tb_top.sv
// self-checking bench for the memory map decoder
`timescale 1ns/100ps
module omd_decoder_tb_top;
    logic clk, rst, mode_select_a, mode_select_b, cfg_prog_we;
    logic acc_valid, acc_write, sel_valid_q, sel_write_q;
    logic rom_present_bit_q, rom_placement_bit_q;
    logic [15:0] acc_addr, sel_offset_q;
    logic [7:0] acc_wdata, cfg_prog_data, ram_reg_map_q, ee_map_q;
    logic [2:0] sel_target_q;
    logic [1:0] mode_q;
    int bad_count = 0;
    int comparisons = 0;
    omd_decoder uut (.*);
    omd_cpu_model cpu (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic end_of_test;
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [15:0] a, input logic [2:0] t,
                       input logic [15:0] o, input bit ko = 1'b1);
        cpu.issue(a, 1'b0, 8'h00);
        chk({13'h0000, sel_target_q}, {13'h0000, t});
        if (ko)
            chk(sel_offset_q, o);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu.issue(a, 1'b1, d);
        chk({13'h0000, sel_target_q}, {13'h0000, omd_pkg::TGT_REG});
        chk({15'h0000, sel_write_q}, 16'h0001);
    endtask
    // mode pins stay put for the whole reset span
    task automatic boot_up(input logic b, input logic a);
        @(negedge clk);
        rst = 1'b1;
        mode_select_b = b;
        mode_select_a = a;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic prog_cfg(input logic [7:0] v);
        @(negedge clk);
        cfg_prog_we = 1'b1;
        cfg_prog_data = v;
        @(negedge clk);
        cfg_prog_we = 1'b0;
    endtask
    task automatic t_expanded;
        boot_up(1'b1, 1'b1);
        chk({14'h0000, mode_q}, 16'h0003);
        chk({ee_map_q, ram_reg_map_q}, 16'h0000);
        acc(16'h0000, omd_pkg::TGT_REG, 16'h0000);
        acc(16'h007f, omd_pkg::TGT_REG, 16'h007f);
        acc(16'h0080, omd_pkg::TGT_RAM, 16'h0080);
        acc(16'h047f, omd_pkg::TGT_RAM, 16'h007f);
        acc(16'h0480, omd_pkg::TGT_EXT, 16'h0480);
        acc(16'h0d80, omd_pkg::TGT_EEPROM, 16'h0000);
        acc(16'h0fff, omd_pkg::TGT_EEPROM, 16'h027f);
        acc(16'h8000, omd_pkg::TGT_ROM, 16'h0000);
        acc(16'hffff, omd_pkg::TGT_ROM, 16'h7fff);
        acc(16'hbe40, omd_pkg::TGT_ROM, 16'h3e40);
        acc(16'h7fff, omd_pkg::TGT_EXT, 16'h7fff);
    endtask
    task automatic t_remap;
        wr(16'h003d, 8'h12);
        acc(16'h2000, omd_pkg::TGT_REG, 16'h0000);
        acc(16'h0000, omd_pkg::TGT_EXT, 16'h0000);
        acc(16'h1000, omd_pkg::TGT_RAM, 16'h0000);
        acc(16'h13ff, omd_pkg::TGT_RAM, 16'h03ff);
        chk({8'h00, ram_reg_map_q}, 16'h0012);
        wr(16'h2037, 8'h30);
        acc(16'h3d80, omd_pkg::TGT_EEPROM, 16'h0000);
        acc(16'h0d80, omd_pkg::TGT_EXT, 16'h0d80);
        chk({8'h00, ee_map_q}, 16'h0030);
        wr(16'h203d, 8'h55);
        acc(16'h5000, omd_pkg::TGT_REG, 16'h0000);
        acc(16'h5400, omd_pkg::TGT_RAM, 16'h0000);
        acc(16'h5480, omd_pkg::TGT_EXT, 16'h5480);
    endtask
    task automatic t_cfg;
        prog_cfg(8'h02);
        boot_up(1'b1, 1'b1);
        chk({15'h0000, rom_placement_bit_q}, 16'h0000);
        acc(16'h0d80, omd_pkg::TGT_ROM, 16'h0d80);
        acc(16'h1000, omd_pkg::TGT_ROM, 16'h1000);
        acc(16'h8000, omd_pkg::TGT_EXT, 16'h8000);
        boot_up(1'b1, 1'b0);
        chk({14'h0000, mode_q}, 16'h0001);
        chk({15'h0000, rom_placement_bit_q}, 16'h0001);
        acc(16'h8000, omd_pkg::TGT_ROM, 16'h0000);
        acc(16'h1000, omd_pkg::TGT_NONE, 16'h0000, 1'b0);
        acc(16'h0080, omd_pkg::TGT_RAM, 16'h0080);
    endtask
    task automatic t_special;
        prog_cfg(8'h07);
        boot_up(1'b0, 1'b1);
        chk({14'h0000, mode_q}, 16'h0002);
        chk({15'h0000, rom_present_bit_q}, 16'h0000);
        acc(16'h8000, omd_pkg::TGT_EXT, 16'h8000);
        acc(16'h0d80, omd_pkg::TGT_EEPROM, 16'h0000);
        boot_up(1'b0, 1'b0);
        chk({14'h0000, mode_q}, 16'h0000);
        acc(16'hbe40, omd_pkg::TGT_BOOT, 16'h0000);
        acc(16'hbfff, omd_pkg::TGT_BOOT, 16'h01bf);
        acc(16'hfffe, omd_pkg::TGT_BOOT, 16'h01be);
        acc(16'h8000, omd_pkg::TGT_ROM, 16'h0000);
        acc(16'h0480, omd_pkg::TGT_NONE, 16'h0000, 1'b0);
    endtask
    initial begin
        rst = 1'b1;
        mode_select_a = 1'b1;
        mode_select_b = 1'b1;
        cfg_prog_we = 1'b0;
        cfg_prog_data = 8'h00;
        t_expanded();
        t_remap();
        t_cfg();
        t_special();
        end_of_test();
    end
    // about 170 cycles are needed; allow far more before giving up
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
endmodule

//--- hw/omd_cfg_byte.sv
// nonvolatile configuration byte held apart from the eeprom array
`timescale 1ns/100ps
module omd_cfg_byte (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic prog_we, // program strobe for the byte
    input wire logic [7:0] prog_data, // value to program
    output logic [7:0] cfg_q = omd_pkg::RST_CONFIG // stored config byte
);
    // kept across reset in silicon; modelled as erased at power-up only,
    // so the value starts from the declaration, not from a reset branch
    always_ff @(posedge clk) begin
        if (prog_we && !rst) begin
            cfg_q <= prog_data;
        end
    end
endmodule

//--- hw/omd_decoder.sv
// memory map decoder top: chooses the target of each cpu access
// Function
// [RULE_01] same on-chip map in single and expanded
// [RULE_02] register block at 0000-007f after reset
// [RULE_03] software write relocates registers to 4k page
// [RULE_04] separate nibbles for ram and register pages
// [RULE_05] ram bits 7:4, registers 3:0, reset zero
// [RULE_06] shared page: ram at x080, alias x400-x47f
// [RULE_07] 1024 byte ram on any 4k page
// [RULE_08] default ram starts at 0080
// [RULE_09] eeprom at 0d80 only when enabled
// [RULE_10] eeprom map write moves eeprom to xd80
// [RULE_11] rom decoded only when presence bit set
// [RULE_12] rom high half, or low half expanded
// [RULE_13] special test mode clears rom presence
// [RULE_14] single chip forces rom placement to one
// [RULE_15] bootstrap rom at be40-bfff gives reset vector
// [RULE_16] bootstrap mode takes vectors from boot rom
// [RULE_17] normal modes leave bootstrap rom undecoded
// [RULE_18] configuration held in separate eeprom byte
// [RULE_19] priority registers, ram, then eeprom and rom
// [RULE_20] unclaimed goes external except single chip; code gives TGT_NONE in boot mode too
`timescale 1ns/100ps
module omd_decoder (
    input wire logic clk, // system clock, 20 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic mode_select_a, // mode pin sampled at reset
    input wire logic mode_select_b, // mode pin sampled at reset
    input wire logic acc_valid, // cpu access strobe
    input wire logic acc_write, // cpu access is a write
    input wire logic [15:0] acc_addr, // cpu address
    input wire logic [7:0] acc_wdata, // cpu write data
    input wire logic cfg_prog_we, // program configuration byte
    input wire logic [7:0] cfg_prog_data, // configuration byte value
    output logic sel_valid_q, // decode result valid
    output logic [2:0] sel_target_q, // decoded target code
    output logic [15:0] sel_offset_q, // offset inside target
    output logic sel_write_q, // registered write flag
    output logic [1:0] mode_q, // latched operating mode
    output logic [7:0] ram_reg_map_q, // mapping register readback
    output logic [7:0] ee_map_q, // eeprom mapping readback
    output logic rom_present_bit_q, // effective rom presence
    output logic rom_placement_bit_q // effective rom placement
);
    omd_pkg::omd_mode_type mode_r;
    logic [7:0] cfg_byte;
    logic [3:0] ram_pg;
    logic [3:0] reg_pg;
    logic [3:0] ee_pg;
    logic [3:0] ee_low;
    logic wr_init;
    logic wr_ee;
    logic reg_hit;
    logic ram_hit;
    logic ee_hit;
    logic rom_hit;
    logic boot_hit;
    logic vec_hit;
    logic rom_on;
    logic rom_ad;
    logic internal_only;
    logic [11:0] pofs;
    logic [2:0] tgt_d;
    logic [15:0] ofs_d;

    // page compare used by every windowed region
    function automatic logic on_page(input logic [15:0] a,
                                     input logic [3:0] pg);
        on_page = (a[15:12] == pg);
    endfunction

    // in-range test on the 12-bit page offset
    function automatic logic in_win(input logic [11:0] o,
                                    input logic [11:0] base,
                                    input logic [11:0] size);
        logic [12:0] top;
        top = {1'b0, base} + {1'b0, size};
        in_win = (o >= base) && ({1'b0, o} < top);
    endfunction

    omd_cfg_byte u_cfg ( // [RULE_18]
        .clk(clk),
        .rst(rst),
        .prog_we(cfg_prog_we),
        .prog_data(cfg_prog_data),
        .cfg_q(cfg_byte)
    );

    omd_map_regs u_map (
        .clk(clk),
        .rst(rst),
        .wr_init(wr_init),
        .wr_ee(wr_ee),
        .wdata(acc_wdata),
        .ram_page_nibble_q(ram_pg),
        .regblock_page_nibble_q(reg_pg),
        .eeprom_page_select_q(ee_pg),
        .ee_low_q(ee_low)
    );

    // mode pins are caught while reset is high, held after release
    always_ff @(posedge clk) begin
        if (rst) begin
            case ({mode_select_b, mode_select_a})
                2'b00: mode_r <= omd_pkg::omd_mode_boot;
                2'b01: mode_r <= omd_pkg::omd_mode_test;
                2'b10: mode_r <= omd_pkg::omd_mode_single;
                default: mode_r <= omd_pkg::omd_mode_expanded;
            endcase
        end
    end

    // rom control bits follow the configuration byte except where the
    // mode overrides them; these are effective values, not stored ones
    always_comb begin
        rom_on = cfg_byte[omd_pkg::CFG_ROM_PRESENT];
        rom_ad = cfg_byte[omd_pkg::CFG_ROM_PLACE];
        case (mode_r)
            omd_pkg::omd_mode_test: rom_on = 1'b0; // [RULE_13]
            omd_pkg::omd_mode_single: rom_ad = 1'b1; // [RULE_14]
            omd_pkg::omd_mode_boot: rom_ad = 1'b1;
            default: ;
        endcase
    end

    assign pofs = acc_addr[11:0];

    // region hits; page registers are shared by all modes
    always_comb begin // [RULE_01]
        reg_hit = on_page(acc_addr, reg_pg) &&
                  in_win(pofs, 12'h000, omd_pkg::REG_SIZE); // [RULE_02]
        ram_hit = 1'b0;
        if (on_page(acc_addr, ram_pg)) begin // [RULE_07]
            if (ram_pg == reg_pg) begin
                // shared page: registers hide the first 128 bytes
                ram_hit = in_win(pofs, omd_pkg::RAM_SHARED_BASE,
                                 omd_pkg::RAM_SIZE); // [RULE_06]
            end else begin
                ram_hit = in_win(pofs, 12'h000, omd_pkg::RAM_SIZE);
            end
        end
        ee_hit = cfg_byte[omd_pkg::CFG_EE_ENABLE] &&
                 on_page(acc_addr, ee_pg) &&
                 in_win(pofs, omd_pkg::EE_BASE, omd_pkg::EE_SIZE); // [RULE_09]
        rom_hit = rom_on && (acc_addr[15] == rom_ad); // [RULE_11] [RULE_12]
        boot_hit = (mode_r == omd_pkg::omd_mode_boot) &&
                   (acc_addr >= omd_pkg::BOOT_BASE) &&
                   (acc_addr <= omd_pkg::BOOT_END); // [RULE_15] [RULE_17]
        vec_hit = (mode_r == omd_pkg::omd_mode_boot) &&
                  (acc_addr >= omd_pkg::VEC_BASE); // [RULE_16]
    end

    // mapping register writes go through the relocated register block
    assign wr_init = acc_valid && acc_write && reg_hit &&
                     (pofs[6:0] == omd_pkg::OFS_RAM_REG_MAP); // [RULE_03]
    assign wr_ee = acc_valid && acc_write && reg_hit &&
                   (pofs[6:0] == omd_pkg::OFS_EEPROM_MAP); // [RULE_10]

    assign internal_only = (mode_r == omd_pkg::omd_mode_single) ||
                           (mode_r == omd_pkg::omd_mode_boot);

    // one target per access; vectors in boot mode are redirected into
    // the boot rom image so the whole vector table comes from it
    always_comb begin // [RULE_19]
        tgt_d = omd_pkg::TGT_NONE;
        ofs_d = 16'h0000;
        if (reg_hit) begin
            tgt_d = omd_pkg::TGT_REG;
            ofs_d = {9'h000, pofs[6:0]};
        end else if (ram_hit) begin
            tgt_d = omd_pkg::TGT_RAM;
            ofs_d = {6'h00, pofs[9:0]};
            if (ram_pg == reg_pg && pofs >= omd_pkg::RAM_ALIAS_BASE) begin
                // displaced first 128 bytes at x400-x47f
                ofs_d = {6'h00, pofs[9:0]}; // [RULE_06]
            end
        end else if (vec_hit) begin
            tgt_d = omd_pkg::TGT_BOOT; // [RULE_16]
            ofs_d = omd_pkg::BOOT_VEC_BASE - omd_pkg::BOOT_BASE +
                    (acc_addr - omd_pkg::VEC_BASE);
        end else if (boot_hit) begin
            tgt_d = omd_pkg::TGT_BOOT;
            ofs_d = acc_addr - omd_pkg::BOOT_BASE;
        end else if (ee_hit) begin
            tgt_d = omd_pkg::TGT_EEPROM;
            ofs_d = {4'h0, pofs - omd_pkg::EE_BASE};
        end else if (rom_hit) begin
            tgt_d = omd_pkg::TGT_ROM;
            ofs_d = {1'b0, acc_addr[14:0]};
        end else if (!internal_only) begin
            tgt_d = omd_pkg::TGT_EXT; // [RULE_20]
            ofs_d = acc_addr;
        end
    end

    // registered decode result, one cycle after the access
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_valid_q <= 1'b0;
            sel_target_q <= omd_pkg::TGT_NONE;
            sel_offset_q <= 16'h0000;
            sel_write_q <= 1'b0;
        end else begin
            sel_valid_q <= acc_valid;
            sel_target_q <= acc_valid ? tgt_d : omd_pkg::TGT_NONE;
            sel_offset_q <= acc_valid ? ofs_d : 16'h0000;
            sel_write_q <= acc_valid && acc_write;
        end
    end

    // status readback; reflects the map registers one cycle late
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= 2'h0;
            ram_reg_map_q <= omd_pkg::RST_RAM_REG_MAP; // [RULE_05]
            ee_map_q <= 8'h00;
            rom_present_bit_q <= 1'b0;
            rom_placement_bit_q <= 1'b0;
        end else begin
            mode_q <= mode_r;
            ram_reg_map_q <= {ram_pg, reg_pg}; // [RULE_04] [RULE_08]
            ee_map_q <= {ee_pg, ee_low};
            rom_present_bit_q <= rom_on;
            rom_placement_bit_q <= rom_ad;
        end
    end
endmodule

//--- hw/omd_map_regs.sv
// mapping registers: ram/register page and eeprom page
`timescale 1ns/100ps
module omd_map_regs (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic wr_init, // write strobe for ram/register map
    input wire logic wr_ee, // write strobe for eeprom map
    input wire logic [7:0] wdata, // write data
    output logic [3:0] ram_page_nibble_q, // ram 4k page
    output logic [3:0] regblock_page_nibble_q, // register block 4k page
    output logic [3:0] eeprom_page_select_q, // eeprom 4k page
    output logic [3:0] ee_low_q // remaining eeprom map bits
);
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_page_nibble_q <= omd_pkg::RST_RAM_REG_MAP[7:4];
            regblock_page_nibble_q <= omd_pkg::RST_RAM_REG_MAP[3:0];
        end else if (wr_init) begin
            ram_page_nibble_q <= wdata[omd_pkg::RAM_NIB_HI:omd_pkg::RAM_NIB_LO];
            regblock_page_nibble_q <=
                wdata[omd_pkg::REG_NIB_HI:omd_pkg::REG_NIB_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            eeprom_page_select_q <= omd_pkg::RST_EEPROM_PAGE;
            ee_low_q <= omd_pkg::RST_LOW_NIBBLE;
        end else if (wr_ee) begin
            eeprom_page_select_q <= wdata[7:4];
            ee_low_q <= wdata[3:0];
        end
    end
endmodule

//--- inc/omd_pkg.sv
// constants and types for the on-chip memory map decoder
package omd_pkg;
    // operating modes from the two mode selects sampled at reset
    typedef enum logic [1:0] {
        omd_mode_boot,
        omd_mode_single,
        omd_mode_test,
        omd_mode_expanded
    } omd_mode_type;

    // decode target codes
    localparam logic [2:0] TGT_NONE = 3'h0;
    localparam logic [2:0] TGT_REG = 3'h1;
    localparam logic [2:0] TGT_RAM = 3'h2;
    localparam logic [2:0] TGT_EEPROM = 3'h3;
    localparam logic [2:0] TGT_ROM = 3'h4;
    localparam logic [2:0] TGT_BOOT = 3'h5;
    localparam logic [2:0] TGT_EXT = 3'h6;

    // internal register offsets inside the register block
    localparam logic [6:0] OFS_EEPROM_MAP = 7'h37;
    localparam logic [6:0] OFS_RAM_REG_MAP = 7'h3d;

    // reset values
    localparam logic [7:0] RST_RAM_REG_MAP = 8'h00;
    localparam logic [3:0] RST_EEPROM_PAGE = 4'h0;
    localparam logic [3:0] RST_LOW_NIBBLE = 4'h0;

    // field positions of the mapping register
    localparam int RAM_NIB_HI = 7;
    localparam int RAM_NIB_LO = 4;
    localparam int REG_NIB_HI = 3;
    localparam int REG_NIB_LO = 0;

    // configuration byte bit positions
    localparam int CFG_ROM_PLACE = 2;
    localparam int CFG_ROM_PRESENT = 1;
    localparam int CFG_EE_ENABLE = 0;
    localparam logic [7:0] RST_CONFIG = 8'h07;

    // region sizes and offsets within a 4k page, then full 16-bit boot rom and vector addresses
    localparam logic [11:0] REG_SIZE = 12'h080;
    localparam logic [11:0] RAM_SIZE = 12'h400;
    localparam logic [11:0] RAM_SHARED_BASE = 12'h080;
    localparam logic [11:0] RAM_ALIAS_BASE = 12'h400;
    localparam logic [11:0] RAM_ALIAS_END = 12'h47f;
    localparam logic [11:0] EE_BASE = 12'hd80;
    localparam logic [11:0] EE_SIZE = 12'h280;
    localparam logic [15:0] BOOT_BASE = 16'hbe40;
    localparam logic [15:0] BOOT_END = 16'hbfff;
    localparam logic [15:0] VEC_BASE = 16'hffc0;
    localparam logic [15:0] BOOT_VEC_BASE = 16'hbfc0;
endpackage
